/* hdl/rfst_defs.svh */
// register offsets, field positions, masks and reset values of the bank
`ifndef RFST_DEFS_SVH
`define RFST_DEFS_SVH

// access port widths
`define RFST_ADDR_W        7
`define RFST_DATA_W        8

// register offsets
`define RFST_ADR_CAP       7'h12
`define RFST_ADR_SYNTH     7'h13
`define RFST_ADR_DIVIDER   7'h1C
`define RFST_ADR_PUMP_OVR  7'h40
`define RFST_ADR_OSC_OVR   7'h41
`define RFST_ADR_LOOP_BW   7'h42
`define RFST_ADR_LOOP_BRK  7'h43
`define RFST_ADR_PUMP_STS  7'h44
`define RFST_ADR_DAC_STS   7'h45
`define RFST_ADR_OSC_STS   7'h46

// writable bit masks, reserved and unused bits store zero
`define RFST_MASK_CAP      8'hFF
`define RFST_MASK_SYNTH    8'h01
`define RFST_MASK_DIVIDER  8'hFC
`define RFST_MASK_PUMP_OVR 8'hFF
`define RFST_MASK_OSC_OVR  8'h3F
`define RFST_MASK_LOOP_BW  8'h3F
`define RFST_MASK_LOOP_BRK 8'h1F

// reset values
`define RFST_RST_CAP       8'h00
`define RFST_RST_SYNTH     8'h01
`define RFST_RST_DIVIDER   8'h00
`define RFST_RST_PUMP_OVR  8'h10
`define RFST_RST_OSC_OVR   8'h08
`define RFST_RST_LOOP_BW   8'h25
`define RFST_RST_LOOP_BRK  8'h04
`define RFST_RST_DATA      8'h00

// field positions
`define RFST_F_RX_MATCH    7:4
`define RFST_F_TX_MATCH    3:0
`define RFST_F_SYNTH_RST   0
`define RFST_F_SWING       7:6
`define RFST_F_CURRENT     5:4
`define RFST_F_IF_INPUT    3
`define RFST_F_IF_FRONT    2
`define RFST_F_TP_ONE      7
`define RFST_F_TP_TWO      6
`define RFST_F_PUMP_OVR_EN 5
`define RFST_F_PUMP_VALUE  4:0
`define RFST_F_PULSE_OFF   5
`define RFST_F_OSC_OVR_EN  4
`define RFST_F_OSC_VALUE   3:0
`define RFST_F_LOOP_BW     5:0
`define RFST_F_LOOP_OPEN   4
`define RFST_F_DAC_VALUE   3:0

// widths of the applied vectors
`define RFST_PUMP_W        5
`define RFST_DAC_W         4
`define RFST_OSC_W         4

`endif

/* hdl/rfst_pkg.sv */
// state type of the synthesizer trim and test register bank
package rfst_pkg;

	typedef struct packed {
		logic [7:0] capacitor_tuning;
		logic [7:0] synth_control;
		logic [7:0] divider_trim;
		logic [7:0] pump_test_override;
		logic [7:0] oscillator_test_override;
		logic [7:0] loop_bandwidth_const;
		logic [7:0] loop_break_control;
		logic [7:0] rdata;
		logic       rvalid;
	} rfst_state_s;

endpackage

/* hdl/rfst_sel_if.sv */
// override versus calibrated value selection bundle
`timescale 1ns/1ps
interface rfst_sel_if #(
	parameter int W = 4
);
	logic         override_en;
	logic [W-1:0] override_value;
	logic [W-1:0] calibrated;
	logic [W-1:0] applied;

	modport owner (
		output override_en,
		output override_value,
		output calibrated,
		input  applied
	);
	modport sel (
		input  override_en,
		input  override_value,
		input  calibrated,
		output applied
	);
endinterface

/* hdl/rfst_override_sel.sv */
// registered selector between an override field and a calibrated value
`timescale 1ns/1ps
module rfst_override_sel #(
	parameter int W = 4
) (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	rfst_sel_if.sel   sel_if
);
	typedef struct packed {
		logic [W-1:0] applied;
	} rfst_sel_state_s;

	rfst_sel_state_s state_r;
	rfst_sel_state_s state_nxt;

	// override wins while enabled, else the calibrated value passes
	always_comb begin
		state_nxt = state_r;
		if (sel_if.override_en) begin
			state_nxt.applied = sel_if.override_value;
		end else begin
			state_nxt.applied = sel_if.calibrated;
		end
	end

	// one flop stage so the applied value is glitch free
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign sel_if.applied = state_r.applied;
endmodule

/* hdl/rfst_regs.sv */
// configuration and test register bank of the synthesizer and trims
`timescale 1ns/1ps
`include "rfst_defs.svh"
module rfst_regs (
	input  wire logic                    clk_sys_i,
	input  wire logic                    rst_n_i,
	// register access from the serial configuration front end
	input  wire logic                    wr_en_i,
	input  wire logic                    rd_en_i,
	input  wire logic [`RFST_ADDR_W-1:0] addr_i,
	input  wire logic [`RFST_DATA_W-1:0] wdata_i,
	output logic      [`RFST_DATA_W-1:0] rdata_o,
	output logic                         rvalid_o,
	// calibrated values from the calibration engine
	input  wire logic [`RFST_PUMP_W-1:0] cal_pump_current_i,
	input  wire logic [`RFST_DAC_W-1:0]  cal_dac_i,
	input  wire logic [`RFST_OSC_W-1:0]  cal_osc_array_i,
	// phase detector pulses towards the charge pump
	input  wire logic                    pump_up_i,
	input  wire logic                    pump_dn_i,
	output logic                         pump_up_o,
	output logic                         pump_dn_o,
	// analog trims and routing
	output logic      [3:0]              rx_match_o,
	output logic      [3:0]              tx_match_o,
	output logic                         synth_reset_low_o,
	output logic      [1:0]              pre_swing_o,
	output logic      [1:0]              pre_current_o,
	output logic                         if_input_route_o,
	output logic                         if_front_route_o,
	output logic                         testpoint_one_sel_o,
	output logic                         testpoint_two_sel_o,
	output logic                         pump_output_pin_gnd_o,
	output logic      [5:0]              loop_bw_constant_o,
	output logic                         loop_open_o,
	output logic      [`RFST_PUMP_W-1:0] pump_current_applied_o,
	output logic      [`RFST_DAC_W-1:0]  cal_dac_applied_o,
	output logic      [`RFST_OSC_W-1:0]  osc_array_applied_o
);

	// register map, offset then the bits that hold state
	//   12h capacitor tuning     rx code [7:4], tx code [3:0]
	//   13h synth control        synthesizer reset low [0]
	//   1Ch divider trim         swing [7:6], current [5:4], routing [3:2]
	//   40h pump test override   test points [7:6], enable [5], value [4:0]
	//   41h oscillator override  pulse off [5], enable [4], value [3:0]
	//   42h loop bandwidth       constant [5:0]
	//   43h loop break control   loop open [4], dac value [3:0]
	//   44h pump current status  applied pump current [4:0], read only
	//   45h cal dac status       applied dac value [3:0], read only
	//   46h osc array status     applied array value [3:0], read only
	// every other offset reads zero and ignores writes

	rfst_pkg::rfst_state_s state_r;
	rfst_pkg::rfst_state_s state_nxt;

	logic [`RFST_DATA_W-1:0] read_mux;

	// the applied vectors lag their inputs by one flop; the trade is one
	// cycle of status latency against no combinational path from the
	// calibration engine through to the read port

	// selector bundles for the three applied vectors
	rfst_sel_if #(.W(`RFST_PUMP_W)) pump_if ();
	rfst_sel_if #(.W(`RFST_DAC_W))  dac_if ();
	rfst_sel_if #(.W(`RFST_OSC_W))  osc_if ();

	assign pump_if.override_en    =
		state_r.pump_test_override[`RFST_F_PUMP_OVR_EN];
	assign pump_if.override_value =
		state_r.pump_test_override[`RFST_F_PUMP_VALUE];
	assign pump_if.calibrated     = cal_pump_current_i;

	// dac override only while the loop is open
	assign dac_if.override_en    =
		state_r.loop_break_control[`RFST_F_LOOP_OPEN];
	assign dac_if.override_value =
		state_r.loop_break_control[`RFST_F_DAC_VALUE];
	assign dac_if.calibrated     = cal_dac_i;

	assign osc_if.override_en    =
		state_r.oscillator_test_override[`RFST_F_OSC_OVR_EN];
	assign osc_if.override_value =
		state_r.oscillator_test_override[`RFST_F_OSC_VALUE];
	assign osc_if.calibrated     = cal_osc_array_i;

	// override or calibrated selection, one flop each
	rfst_override_sel #(.W(`RFST_PUMP_W)) u_pump_sel (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.sel_if    (pump_if)
	);

	rfst_override_sel #(.W(`RFST_DAC_W)) u_dac_sel (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.sel_if    (dac_if)
	);

	rfst_override_sel #(.W(`RFST_OSC_W)) u_osc_sel (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.sel_if    (osc_if)
	);

	// read data selection; unmapped offsets answer zero
	// decoded from addr_i alone, the read strobe only gates the capture
	always_comb begin
		read_mux = `RFST_RST_DATA;
		unique case (addr_i)
			`RFST_ADR_CAP: begin
				read_mux = state_r.capacitor_tuning;
			end
			`RFST_ADR_SYNTH: begin
				read_mux = state_r.synth_control;
			end
			`RFST_ADR_DIVIDER: begin
				read_mux = state_r.divider_trim;
			end
			`RFST_ADR_PUMP_OVR: begin
				read_mux = state_r.pump_test_override;
			end
			`RFST_ADR_OSC_OVR: begin
				read_mux = state_r.oscillator_test_override;
			end
			`RFST_ADR_LOOP_BW: begin
				read_mux = state_r.loop_bandwidth_const;
			end
			`RFST_ADR_LOOP_BRK: begin
				read_mux = state_r.loop_break_control;
			end
			// applied pump current, upper bits zero
			`RFST_ADR_PUMP_STS: begin
				read_mux = `RFST_DATA_W'(pump_if.applied);
			end
			`RFST_ADR_DAC_STS: begin
				read_mux = `RFST_DATA_W'(dac_if.applied);
			end
			`RFST_ADR_OSC_STS: begin
				read_mux = `RFST_DATA_W'(osc_if.applied);
			end
			default: begin
				read_mux = `RFST_RST_DATA;
			end
		endcase
	end

	// access timing, a read and a write strobe may share a cycle:
	//   edge n   strobe, address and write data are taken
	//   n+1      written field visible, rvalid_o high with rdata_o
	//   n+2      applied vectors reflect a changed override
	// rdata_o holds until the next read strobe, so a slow serial
	// front end may fetch it at leisure; a read and a write to one
	// offset in the same cycle return the old contents

	// register writes and read capture
	always_comb begin
		state_nxt        = state_r;
		state_nxt.rvalid = rd_en_i;
		// read sees the value before a same-cycle write lands
		if (rd_en_i) begin
			state_nxt.rdata = read_mux;
		end
		// masks drop writes to reserved bits; status is read only
		if (wr_en_i) begin
			unique case (addr_i)
				`RFST_ADR_CAP: begin
					state_nxt.capacitor_tuning =
						wdata_i & `RFST_MASK_CAP;
				end
				`RFST_ADR_SYNTH: begin
					state_nxt.synth_control =
						wdata_i & `RFST_MASK_SYNTH;
				end
				`RFST_ADR_DIVIDER: begin
					state_nxt.divider_trim =
						wdata_i & `RFST_MASK_DIVIDER;
				end
				`RFST_ADR_PUMP_OVR: begin
					state_nxt.pump_test_override =
						wdata_i & `RFST_MASK_PUMP_OVR;
				end
				`RFST_ADR_OSC_OVR: begin
					state_nxt.oscillator_test_override =
						wdata_i & `RFST_MASK_OSC_OVR;
				end
				`RFST_ADR_LOOP_BW: begin
					state_nxt.loop_bandwidth_const =
						wdata_i & `RFST_MASK_LOOP_BW;
				end
				`RFST_ADR_LOOP_BRK: begin
					state_nxt.loop_break_control =
						wdata_i & `RFST_MASK_LOOP_BRK;
				end
				default: begin
					state_nxt.rvalid = state_nxt.rvalid;
				end
			endcase
		end
	end

	// state register with the power-on defaults; the applied vectors
	// reset to zero in the selectors and take the calibrated inputs
	// at the first edge after release
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r.capacitor_tuning         <= `RFST_RST_CAP;
			state_r.synth_control            <= `RFST_RST_SYNTH;
			state_r.divider_trim             <= `RFST_RST_DIVIDER;
			state_r.pump_test_override       <= `RFST_RST_PUMP_OVR;
			state_r.oscillator_test_override <= `RFST_RST_OSC_OVR;
			state_r.loop_bandwidth_const     <= `RFST_RST_LOOP_BW;
			state_r.loop_break_control       <= `RFST_RST_LOOP_BRK;
			state_r.rdata                    <= `RFST_RST_DATA;
			state_r.rvalid                   <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// register access answer
	// rvalid_o is a one-cycle pulse, rdata_o keeps the last answer
	assign rdata_o  = state_r.rdata;
	assign rvalid_o = state_r.rvalid;

	// codes step the matching arrays in fixed capacitor increments
	// matching capacitor codes
	assign rx_match_o = state_r.capacitor_tuning[`RFST_F_RX_MATCH];
	assign tx_match_o = state_r.capacitor_tuning[`RFST_F_TX_MATCH];

	// resets only the synthesizer, active low
	assign synth_reset_low_o = state_r.synth_control[`RFST_F_SYNTH_RST];

	// swing fractions assume current code 00
	assign pre_swing_o   = state_r.divider_trim[`RFST_F_SWING];
	assign pre_current_o = state_r.divider_trim[`RFST_F_CURRENT];

	// pin routing; both set is left to the analog side
	assign if_input_route_o = state_r.divider_trim[`RFST_F_IF_INPUT];
	assign if_front_route_o = state_r.divider_trim[`RFST_F_IF_FRONT];

	// test point selects, output grounded when neither set
	assign testpoint_one_sel_o =
		state_r.pump_test_override[`RFST_F_TP_ONE];
	assign testpoint_two_sel_o =
		state_r.pump_test_override[`RFST_F_TP_TWO];
	assign pump_output_pin_gnd_o =
		~(testpoint_one_sel_o | testpoint_two_sel_o);

	// limitation: a pulse already high when the disable bit is written
	// is cut only once the bit settles after that clock edge
	// pulse gating kept combinational to add no phase delay
	assign pump_up_o = pump_up_i &
		~state_r.oscillator_test_override[`RFST_F_PULSE_OFF];
	assign pump_dn_o = pump_dn_i &
		~state_r.oscillator_test_override[`RFST_F_PULSE_OFF];

	// software raises the constant for the faster data rates
	// bandwidth constant straight from its register
	assign loop_bw_constant_o =
		state_r.loop_bandwidth_const[`RFST_F_LOOP_BW];

	// the dac override only takes effect while this flag is high
	// loop open flag
	assign loop_open_o = state_r.loop_break_control[`RFST_F_LOOP_OPEN];

	// applied vectors, same flops as the status readback
	assign pump_current_applied_o = pump_if.applied;
	assign cal_dac_applied_o      = dac_if.applied;
	assign osc_array_applied_o    = osc_if.applied;

endmodule

/* verification/rfst_regs_monitor.sv */
// assertion checker on the ports of the trim and test register bank
`timescale 1ns/1ps
module rfst_regs_monitor (
	input wire logic       clk_sys_i,
	input wire logic       rst_n_i,
	input wire logic       wr_en_i,
	input wire logic       rd_en_i,
	input wire logic [6:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic       rvalid_o,
	input wire logic       pump_up_i,
	input wire logic       pump_dn_i,
	input wire logic       pump_up_o,
	input wire logic       pump_dn_o,
	input wire logic [3:0] rx_match_o,
	input wire logic [3:0] tx_match_o,
	input wire logic       synth_reset_low_o,
	input wire logic [1:0] pre_swing_o,
	input wire logic [1:0] pre_current_o,
	input wire logic       if_input_route_o,
	input wire logic       if_front_route_o,
	input wire logic       testpoint_one_sel_o,
	input wire logic       testpoint_two_sel_o,
	input wire logic       pump_output_pin_gnd_o,
	input wire logic [5:0] loop_bw_constant_o,
	input wire logic       loop_open_o,
	input wire logic [4:0] pump_current_applied_o,
	input wire logic [3:0] cal_dac_applied_o,
	input wire logic [3:0] osc_array_applied_o
);
	default clocking mon_cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	// per-register write decode, keeps the properties short
	logic wr_cap, wr_div, wr_pmp, wr_osc, wr_brk;
	assign wr_cap = wr_en_i && addr_i == 7'h12;
	assign wr_div = wr_en_i && addr_i == 7'h1C;
	assign wr_pmp = wr_en_i && addr_i == 7'h40;
	assign wr_osc = wr_en_i && addr_i == 7'h41;
	assign wr_brk = wr_en_i && addr_i == 7'h43;

	a_cap_nibbles: assert property (wr_cap |=>
		{rx_match_o, tx_match_o} == $past(wdata_i))
		else $error("capacitor codes not taken");
	a_synth_reset: assert property (wr_en_i && addr_i == 7'h13 |=>
		synth_reset_low_o == $past(wdata_i[0]))
		else $error("synth reset bit not taken");
	a_divider_fields: assert property (wr_div |=>
		{pre_swing_o, pre_current_o, if_input_route_o,
		if_front_route_o} == $past(wdata_i[7:2]))
		else $error("divider trim fields not taken");
	a_pin_ground: assert property (pump_output_pin_gnd_o ==
		!(testpoint_one_sel_o || testpoint_two_sel_o))
		else $error("pump pin ground select wrong");
	a_pulse_source: assert property ((!pump_up_o || pump_up_i) &&
		(!pump_dn_o || pump_dn_i))
		else $error("pump pulse without source");
	a_pulse_block: assert property (wr_osc && wdata_i[5] |=>
		!pump_up_o && !pump_dn_o)
		else $error("pump pulse not suppressed");
	a_pump_status: assert property (wr_pmp && wdata_i[5]
		##1 !wr_pmp |=> pump_current_applied_o == $past(wdata_i[4:0], 2))
		else $error("pump override not applied");
	a_osc_status: assert property (wr_osc && wdata_i[4]
		##1 !wr_osc |=> osc_array_applied_o == $past(wdata_i[3:0], 2))
		else $error("array override not applied");
	a_dac_status: assert property (wr_brk && wdata_i[4]
		##1 !wr_brk |=> cal_dac_applied_o == $past(wdata_i[3:0], 2))
		else $error("dac override not applied");
	a_unmapped_zero: assert property (rd_en_i && addr_i == 7'h7F |=>
		rvalid_o && rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_break_readback: assert property (rd_en_i && addr_i == 7'h43 &&
		!wr_en_i |=> rdata_o[7:4] == {3'h0, loop_open_o})
		else $error("loop break readback wrong");
endmodule

bind rfst_regs rfst_regs_monitor u_mon (.clk_sys_i, .rst_n_i, .wr_en_i,
	.rd_en_i, .addr_i, .wdata_i, .rdata_o, .rvalid_o, .pump_up_i, .pump_dn_i,
	.pump_up_o, .pump_dn_o, .rx_match_o, .tx_match_o, .synth_reset_low_o,
	.pre_swing_o, .pre_current_o, .if_input_route_o, .if_front_route_o,
	.testpoint_one_sel_o, .testpoint_two_sel_o, .pump_output_pin_gnd_o,
	.loop_bw_constant_o, .loop_open_o, .pump_current_applied_o,
	.cal_dac_applied_o, .osc_array_applied_o);

/* verification/rfst_regs_tb_top.sv */
// self-checking bench of the trim and test register bank
`timescale 1ns/1ps
`define RFST_CHK(nm, ex, got) begin cmp_count++; \
	if ((got) !== (ex)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module rfst_regs_tb_top;
	logic       clk_sys_i, rst_n_i, wr_en_i, rd_en_i, rvalid_o;
	logic       pump_up_i, pump_dn_i, pump_up_o, pump_dn_o;
	logic       synth_reset_low_o, if_input_route_o, if_front_route_o;
	logic       testpoint_one_sel_o, testpoint_two_sel_o, loop_open_o;
	logic       pump_output_pin_gnd_o;
	logic [6:0] addr_i;
	logic [7:0] wdata_i, rdata_o;
	logic [5:0] loop_bw_constant_o;
	logic [4:0] cal_pump_current_i, pump_current_applied_o;
	logic [3:0] cal_dac_i, cal_osc_array_i, rx_match_o, tx_match_o;
	logic [3:0] cal_dac_applied_o, osc_array_applied_o;
	logic [1:0] pre_swing_o, pre_current_o;
	int         n_errors, cmp_count, cyc;

	rfst_regs u_dut (.clk_sys_i, .rst_n_i, .wr_en_i, .rd_en_i, .addr_i,
		.wdata_i, .rdata_o, .rvalid_o, .cal_pump_current_i, .cal_dac_i,
		.cal_osc_array_i, .pump_up_i, .pump_dn_i, .pump_up_o, .pump_dn_o,
		.rx_match_o, .tx_match_o, .synth_reset_low_o, .pre_swing_o,
		.pre_current_o, .if_input_route_o, .if_front_route_o,
		.testpoint_one_sel_o, .testpoint_two_sel_o, .pump_output_pin_gnd_o,
		.loop_bw_constant_o, .loop_open_o, .pump_current_applied_o,
		.cal_dac_applied_o, .osc_array_applied_o);

	// free-running 50 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// hang guard, the whole run needs well under 1000 cycles
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			test_done();
		end
	end

	// one strobe cycle, inputs moved 1 ns after the edge
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		wr_en_i = 1'b1;
		addr_i = a;
		wdata_i = d;
		@(posedge clk_sys_i);
		#1;
		wr_en_i = 1'b0;
	endtask

	// answer is checked 1 ns after the edge that takes the strobe
	task automatic rd(input logic [6:0] a, input logic [7:0] ex);
		@(posedge clk_sys_i);
		#1;
		rd_en_i = 1'b1;
		addr_i = a;
		@(posedge clk_sys_i);
		#1;
		rd_en_i = 1'b0;
		`RFST_CHK("rvalid", 1'b1, rvalid_o)
		`RFST_CHK("rdata", ex, rdata_o)
	endtask

	task automatic t_reset();
		`RFST_CHK("synth_rst", 1'b1, synth_reset_low_o)
		`RFST_CHK("pin_gnd", 1'b1, pump_output_pin_gnd_o)
		rd(7'h12, 8'h00);
		rd(7'h13, 8'h01);
		rd(7'h1C, 8'h00);
		rd(7'h40, 8'h10);
		rd(7'h41, 8'h08);
		rd(7'h42, 8'h25);
		rd(7'h43, 8'h04);
		rd(7'h44, 8'h0A);
		rd(7'h45, 8'h03);
		rd(7'h46, 8'h05);
		$display("t_reset done");
	endtask

	task automatic t_trims();
		wr(7'h12, 8'h7A);
		`RFST_CHK("rx_match", 4'h7, rx_match_o)
		`RFST_CHK("tx_match", 4'hA, tx_match_o)
		wr(7'h13, 8'hFE);
		`RFST_CHK("synth_rst", 1'b0, synth_reset_low_o)
		rd(7'h13, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(7'h1C, {i[1:0], ~i[1:0], i[1:0], 2'h3});
			`RFST_CHK("swing", i[1:0], pre_swing_o)
			`RFST_CHK("current", ~i[1:0], pre_current_o)
			`RFST_CHK("if_in", i[1], if_input_route_o)
			`RFST_CHK("if_front", i[0], if_front_route_o)
			rd(7'h1C, {i[1:0], ~i[1:0], i[1:0], 2'h0});
			wr(7'h40, {i[1:0], 6'h10});
			`RFST_CHK("tp1", i[1], testpoint_one_sel_o)
			`RFST_CHK("tp2", i[0], testpoint_two_sel_o)
			`RFST_CHK("gnd", i == 0, pump_output_pin_gnd_o)
		end
		wr(7'h42, 8'hFF);
		`RFST_CHK("loop_bw", 6'h3F, loop_bw_constant_o)
		rd(7'h42, 8'h3F);
		$display("t_trims done");
	endtask

	task automatic t_overrides();
		wr(7'h40, 8'h3F);
		rd(7'h44, 8'h1F);
		`RFST_CHK("pump_app", 5'h1F, pump_current_applied_o)
		wr(7'h40, 8'h1F);
		cal_pump_current_i = 5'h15;
		rd(7'h44, 8'h15);
		wr(7'h41, 8'h1C);
		rd(7'h46, 8'h0C);
		`RFST_CHK("osc_app", 4'hC, osc_array_applied_o)
		wr(7'h41, 8'hCC);
		rd(7'h41, 8'h0C);
		rd(7'h46, 8'h05);
		wr(7'h43, 8'h09);
		rd(7'h45, 8'h03);
		wr(7'h43, 8'hF9);
		`RFST_CHK("loop_open", 1'b1, loop_open_o)
		rd(7'h45, 8'h09);
		`RFST_CHK("dac_app", 4'h9, cal_dac_applied_o)
		rd(7'h43, 8'h19);
		$display("t_overrides done");
	endtask

	task automatic t_pulses_unmapped();
		pump_up_i = 1'b1;
		pump_dn_i = 1'b1;
		#1;
		`RFST_CHK("up_on", 1'b1, pump_up_o)
		wr(7'h41, 8'h20);
		`RFST_CHK("up_off", 1'b0, pump_up_o)
		`RFST_CHK("dn_off", 1'b0, pump_dn_o)
		wr(7'h41, 8'h00);
		`RFST_CHK("dn_on", 1'b1, pump_dn_o)
		wr(7'h44, 8'hFF);
		rd(7'h44, 8'h15);
		wr(7'h7F, 8'h55);
		rd(7'h7F, 8'h00);
		$display("t_pulses_unmapped done");
	endtask

	// reset for two cycles, then the scenarios in turn
	initial begin
		{wr_en_i, rd_en_i, pump_up_i, pump_dn_i} = 4'h0;
		addr_i = 7'h00;
		wdata_i = 8'h00;
		cal_pump_current_i = 5'h0A;
		cal_dac_i = 4'h3;
		cal_osc_array_i = 4'h5;
		rst_n_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		rst_n_i = 1'b1;
		t_reset();
		t_trims();
		t_overrides();
		t_pulses_unmapped();
		test_done();
	end
endmodule
